// file: src/bcm_cfg.svh
/*
 Register offsets, field positions, reset values and counts of the bus
 collision port. Assumes nothing; definitions only.
*/
`ifndef BCM_CFG_SVH
`define BCM_CFG_SVH
`define BCM_OFF_CTRL1 8'h00
`define BCM_OFF_CTRL2 8'h04
`define BCM_OFF_STAT  8'h08
`define BCM_OFF_BUF   8'h0c
`define BCM_OFF_RATE  8'h10
`define BCM_OFF_FLAGS 8'h14
`define BCM_C1_WRITE_COLLISION_FLAG   7
`define BCM_C1_EN     5
`define BCM_C2_ACKDT  5
`define BCM_C2_ACK    4
`define BCM_C2_STOP   2
`define BCM_C2_RS     1
`define BCM_C2_ST     0
`define BCM_ST_STOP   4
`define BCM_ST_START  3
`define BCM_ST_FREE   2
`define BCM_ST_PEND   1
`define BCM_ST_BF     0
`define BCM_FL_EVT    0
`define BCM_FL_BCOL   1
`define BCM_RATE_RST  8'h04
`define BCM_SETTLE    8'h02
`define BCM_BYTE_RST  8'h00
`define BCM_TX_LAST   4'h7
`define BCM_TX_ACK    4'h8
`endif

// file: src/bcm_pkg.sv
/*
 Types of the bus collision port: operations, command word, pin pair and
 link-side states. Assumes the constants header beside it.
*/
package bcm_pkg;
	typedef enum logic [2:0] {OP_START, OP_RESTART, OP_STOP, OP_ACK, OP_TX} bcm_op_t;
	typedef struct packed {
		bcm_op_t    op;
		logic [7:0] data;
		logic       ack_bit;
		logic [7:0] reload;
	} bcm_cmd_t;
	typedef struct packed {
		logic sda;
		logic scl;
	} bcm_pins_t;
	typedef enum logic [4:0] {
		L_IDLE, L_ST_CHK, L_ST_WAIT, L_ST_HOLD,
		L_RS_SDA, L_RS_CNT1, L_RS_SCL, L_RS_CNT, L_RS_HOLD,
		L_SP_SDA, L_SP_SCL, L_SP_CNT, L_SP_CHK,
		L_AK_LOW, L_AK_WAIT, L_AK_HIGH,
		L_TX_LOW, L_TX_WAIT, L_TX_HIGH
	} bcm_state_t;
endpackage

// file: src/bcm_top.sv
/*
 Multi-master two-wire port with arbitration and bus collision detection:
 APB register file on pclk, line sequencer on bus_clk.
 Assumes open-drain SDA/SCL resolved outside from the enables, and a
 free-running bus_clk.
*/
// Summary of operation
// (R1) Sending a one, low SDA while SCL high flags collision, port idles.
// (R2) Collision in a byte halts shifting, clears buffer full, frees lines.
// (R3) Collision aborts start/restart/stop/ack, frees lines, clears request bit.
// (R4) After collision keep watching; bus Stop sets port event flag.
// (R5) Buffer write after collision sends the byte from its first bit.
// (R6) Detect Start/Stop; bus free when stop seen or neither seen.
// (R7) SDA or SCL low when Start begins aborts it with collision.
// (R8) SCL low while SDA still high in Start is a collision.
// (R9) Start: SDA high loads counter; early SDA low asserts SDA at once.
// (R10) After SDA low, count to zero then pull SCL; low SCL allowed.
// (R11) Restart: SDA high, count, free SCL; SCL high with SDA low collides.
// (R12) Restart count: SDA falling is fine, SCL falling first collides.
// (R13) Restart with both high: pull SDA, count, then pull SCL regardless.
// (R14) Stop: SDA low frees SCL, SCL high counts, release SDA, low SDA collides.
// (R15) Stop: SCL low after release before SDA floats is a collision.
// (R16) Start-seen and stop-seen flags clear on reset and when disabled.
// (R17) Buffer write during busy port is ignored and sets write collision.
// (R18) SDA and SCL are synchronised before any comparison.
// (R19) Rate counter decrements each cycle from reload; zero means time-out.
`timescale 1ns/1ps
`default_nettype none
`include "bcm_cfg.svh"

module bcm_top (
	// APB
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Line side
	input  wire logic               bus_clk,
	input  wire bcm_pkg::bcm_pins_t line_in,
	output bcm_pkg::bcm_pins_t      line_o,
	output bcm_pkg::bcm_pins_t      line_oe
);
	import bcm_pkg::*;

	// pclk domain state
	logic       en;
	logic       write_collision_flag;
	logic       ackdt;
	logic [3:0] reqs;
	logic [7:0] shbuf;
	logic [7:0] reload;
	logic       bf;
	logic       pend;
	logic       bcol;
	logic       pevt;
	logic       req_t;
	bcm_cmd_t   cmd;
	logic [4:0] s1;
	logic [4:0] s2;
	logic [4:0] s3;

	// bus_clk domain state
	bcm_state_t state;
	bcm_state_t next_state;
	logic       lr1;
	logic       lrst_n;
	logic [1:0] ls1;
	logic [1:0] ls2;
	logic [1:0] ls3;
	bcm_pins_t  ps1;
	bcm_pins_t  ps2;
	bcm_pins_t  pd;
	logic [7:0] cnt;
	logic [7:0] next_cnt;
	logic [7:0] bits;
	logic [7:0] next_bits;
	logic [3:0] idx;
	logic [3:0] next_idx;
	logic       sda_low;
	logic       scl_low;
	logic       next_sda;
	logic       next_scl;
	logic       fin;
	logic       coll;
	logic       done_t;
	logic       coll_t;
	logic       evt_t;
	logic       start_seen;
	logic       stop_seen;

	// APB decode
	wire hit_c1  = paddr == `BCM_OFF_CTRL1;
	wire hit_c2  = paddr == `BCM_OFF_CTRL2;
	wire hit_st  = paddr == `BCM_OFF_STAT;
	wire hit_buf = paddr == `BCM_OFF_BUF;
	wire hit_rt  = paddr == `BCM_OFF_RATE;
	wire hit_fl  = paddr == `BCM_OFF_FLAGS;
	wire mapped  = hit_c1 | hit_c2 | hit_st | hit_buf | hit_rt | hit_fl;
	wire acc     = psel & penable;
	wire wr      = acc & pwrite & mapped;
	wire wr_c1   = wr & hit_c1;
	wire wr_c2   = wr & hit_c2;
	wire wr_buf  = wr & hit_buf;
	wire wr_rt   = wr & hit_rt;
	wire wr_fl   = wr & hit_fl;

	// Link events back in pclk
	wire done_p    = s2[0] ^ s3[0];
	wire coll_p    = s2[1] ^ s3[1];
	wire evt_p     = s2[2] ^ s3[2];
	wire start_s_p = s2[3];
	wire stop_s_p  = s2[4];
	wire bus_free  = stop_s_p | ~(start_s_p | stop_s_p); // R6

	// One request at a time: start, restart, stop, then ack
	wire [3:0] req_in = {pwdata[`BCM_C2_ACK], pwdata[`BCM_C2_STOP], pwdata[`BCM_C2_RS], pwdata[`BCM_C2_ST]};
	wire [3:0] pick   = req_in[0] ? 4'h1 : req_in[1] ? 4'h2 : req_in[2] ? 4'h4 : req_in[3] ? 4'h8 : 4'h0;
	wire       go_c2  = wr_c2 & en & ~pend & (|req_in);
	wire       go_buf = wr_buf & en & ~pend;
	wire       write_collision_flag_set = wr_buf & pend; // R17
	wire       go     = go_c2 | go_buf;
	// Ack data written together with its request must take effect at once
	wire       ack_now = wr_c2 ? pwdata[`BCM_C2_ACKDT] : ackdt;
	wire bcm_op_t go_op = go_buf ? OP_TX : pick[0] ? OP_START : pick[1] ? OP_RESTART : pick[2] ? OP_STOP : OP_ACK;
	wire [7:0] c1_rd  = {write_collision_flag, 1'b0, en, 5'h00};
	wire [7:0] c2_rd  = {2'b00, ackdt, reqs[3], 1'b0, reqs[2], reqs[1], reqs[0]};
	wire [7:0] st_rd  = {3'h0, stop_s_p, start_s_p, bus_free, pend, bf};
	wire [7:0] fl_rd  = {6'h00, bcol, pevt};
	wire [7:0] rd_mux = hit_c1 ? c1_rd : hit_c2 ? c2_rd : hit_st ? st_rd : hit_buf ? shbuf :
	                    hit_rt ? reload : hit_fl ? fl_rd : 8'h00;

	assign pready  = 1'b1;
	assign pslverr = acc & ~mapped;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			s1     <= 5'h00;
			s2     <= 5'h00;
			s3     <= 5'h00;
		end else begin
			if (psel & ~penable)
				prdata <= {24'h00_0000, rd_mux};
			s1 <= {stop_seen, start_seen, evt_t, coll_t, done_t};
			s2 <= s1;
			s3 <= s2;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en     <= 1'b0;
			ackdt  <= 1'b0;
			reload <= `BCM_RATE_RST;
		end else begin
			if (wr_c1)
				en <= pwdata[`BCM_C1_EN];
			if (wr_c2)
				ackdt <= pwdata[`BCM_C2_ACKDT];
			if (wr_rt)
				reload <= pwdata[7:0];
		end
	end

	// Command handed to the link, held while pend is high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shbuf <= `BCM_BYTE_RST;
			cmd   <= '0;
			req_t <= 1'b0;
			pend  <= 1'b0;
			reqs  <= 4'h0;
		end else begin
			if (wr_buf & ~pend)
				shbuf <= pwdata[7:0];
			if (go) begin
				cmd   <= '{go_op, pwdata[7:0], ack_now, reload}; // R5
				req_t <= ~req_t;
				pend  <= 1'b1;
			end else if (done_p)
				pend <= 1'b0;
			if (done_p)
				reqs <= 4'h0; // R3
			else if (go_c2)
				reqs <= pick;
		end
	end

	// Flags: the hardware set wins over a software clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bf   <= 1'b0;
			write_collision_flag <= 1'b0;
			bcol <= 1'b0;
			pevt <= 1'b0;
		end else begin
			if (go_buf)
				bf <= 1'b1;
			else if (done_p)
				bf <= 1'b0; // R2
			if (write_collision_flag_set)
				write_collision_flag <= 1'b1; // R17
			else if (wr_c1 & ~pwdata[`BCM_C1_WRITE_COLLISION_FLAG])
				write_collision_flag <= 1'b0;
			if (coll_p)
				bcol <= 1'b1;
			else if (wr_fl & pwdata[`BCM_FL_BCOL])
				bcol <= 1'b0;
			if (evt_p)
				pevt <= 1'b1; // R4
			else if (wr_fl & pwdata[`BCM_FL_EVT])
				pevt <= 1'b0;
		end
	end

	AST_WRITE_COLLISION_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
		write_collision_flag_set && !done_p |=> write_collision_flag && $stable(shbuf) && pend)
		else $error("busy buffer write not refused"); // R17
	AST_REQ_CLR: assert property (@(posedge pclk) disable iff (!presetn)
		done_p |=> reqs == 4'h0 && !bf && !pend) else $error("request bits not cleared at end"); // R3

	// bus_clk domain: reset release synchronised to the link clock
	always_ff @(posedge bus_clk or negedge presetn) begin
		if (!presetn) begin
			lr1    <= 1'b0;
			lrst_n <= 1'b0;
		end else begin
			lr1    <= 1'b1;
			lrst_n <= lr1;
		end
	end

	wire       en_s  = ls2[1];
	wire       req_p = ls2[0] ^ ls3[0];
	wire       sda_s = ps2.sda;
	wire       scl_s = ps2.scl;
	wire       tmo   = cnt == 8'h00; // R19
	wire [7:0] ld    = cmd.reload;
	wire       start_det = scl_s & pd.scl & pd.sda & ~sda_s;
	wire       stop_det  = scl_s & pd.scl & ~pd.sda & sda_s;
	wire       abort = ~en_s & (state != L_IDLE | req_p);
	wire       bit_one = ~sda_low & (idx < `BCM_TX_ACK);

	assign line_o  = '{1'b0, 1'b0};
	assign line_oe = '{sda_low, scl_low};

	always_comb begin
		next_state = state;
		next_cnt   = tmo ? cnt : cnt - 8'h01; // R19
		next_sda   = sda_low;
		next_scl   = scl_low;
		next_bits  = bits;
		next_idx   = idx;
		fin        = 1'b0;
		coll       = 1'b0;
		unique case (state)
			L_IDLE: if (req_p) begin
				unique case (cmd.op)
					OP_START: begin
						next_sda   = 1'b0;
						next_scl   = 1'b0;
						next_cnt   = `BCM_SETTLE;
						next_state = L_ST_CHK;
					end
					OP_RESTART: begin
						next_sda   = 1'b0;
						next_state = L_RS_SDA;
					end
					OP_STOP: begin
						next_sda   = 1'b1;
						next_state = L_SP_SDA;
					end
					OP_ACK: begin
						next_scl   = 1'b1;
						next_sda   = ~cmd.ack_bit;
						next_cnt   = ld;
						next_state = L_AK_LOW;
					end
					OP_TX: begin
						next_bits  = cmd.data; // R5
						next_idx   = 4'h0;
						next_scl   = 1'b1;
						next_sda   = ~cmd.data[7];
						next_cnt   = ld;
						next_state = L_TX_LOW;
					end
					default: fin = 1'b1;
				endcase
			end
			// Wait out the sync lag, else our own release reads as a low line
			L_ST_CHK: if (tmo) begin
				if (!sda_s || !scl_s)
					coll = 1'b1; // R7
				else begin
					next_cnt   = ld; // R9
					next_state = L_ST_WAIT;
				end
			end
			L_ST_WAIT: if (sda_s && !scl_s)
				coll = 1'b1; // R8
			else if (!sda_s || tmo) begin
				next_sda   = 1'b1; // R9
				next_cnt   = ld;
				next_state = L_ST_HOLD;
			end
			L_ST_HOLD: if (tmo) begin
				next_scl = 1'b1; // R10
				fin      = 1'b1;
			end
			L_RS_SDA: if (sda_s) begin
				next_cnt   = ld; // R11
				next_state = L_RS_CNT1;
			end
			L_RS_CNT1: if (tmo) begin
				next_scl   = 1'b0;
				next_state = L_RS_SCL;
			end
			L_RS_SCL: if (scl_s) begin
				if (!sda_s)
					coll = 1'b1; // R11
				else begin
					next_cnt   = ld;
					next_state = L_RS_CNT;
				end
			end
			L_RS_CNT: if (!scl_s && sda_s)
				coll = 1'b1; // R12
			else if (!sda_s || tmo) begin
				next_sda   = 1'b1; // R13
				next_cnt   = ld;
				next_state = L_RS_HOLD;
			end
			L_RS_HOLD: if (tmo) begin
				next_scl = 1'b1; // R13
				fin      = 1'b1;
			end
			L_SP_SDA: if (!sda_s) begin
				next_scl   = 1'b0; // R14
				next_state = L_SP_SCL;
			end
			L_SP_SCL: if (scl_s) begin
				next_cnt   = ld;
				next_state = L_SP_CNT;
			end
			L_SP_CNT: if (!scl_s)
				coll = 1'b1; // R15
			else if (tmo) begin
				next_sda   = 1'b0;
				next_cnt   = ld;
				next_state = L_SP_CHK;
			end
			L_SP_CHK: if (tmo) begin
				coll = ~sda_s; // R14
				fin  = sda_s;
			end
			L_AK_LOW: if (tmo) begin
				next_scl   = 1'b0;
				next_state = L_AK_WAIT;
			end
			L_AK_WAIT: if (scl_s) begin
				next_cnt   = ld;
				next_state = L_AK_HIGH;
			end
			L_AK_HIGH: if (cmd.ack_bit && !sda_s)
				coll = 1'b1; // R3
			else if (tmo) begin
				next_scl = 1'b1;
				fin      = 1'b1;
			end
			L_TX_LOW: if (tmo) begin
				next_scl   = 1'b0;
				next_state = L_TX_WAIT;
			end
			L_TX_WAIT: if (scl_s) begin
				next_cnt   = ld;
				next_state = L_TX_HIGH;
			end
			L_TX_HIGH: if (bit_one && !sda_s)
				coll = 1'b1; // R1
			else if (tmo) begin
				next_scl = 1'b1;
				if (idx == `BCM_TX_ACK)
					fin = 1'b1;
				else begin
					next_idx   = idx + 4'h1;
					next_bits  = {bits[6:0], 1'b0};
					next_sda   = (idx == `BCM_TX_LAST) ? 1'b0 : ~bits[6];
					next_cnt   = ld;
					next_state = L_TX_LOW;
				end
			end
		endcase
		// A collision frees both lines and drops the sequence at once
		if (coll) begin
			next_state = L_IDLE; // R2
			next_sda   = 1'b0;
			next_scl   = 1'b0;
		end
		if (fin)
			next_state = L_IDLE;
		if (!en_s) begin
			next_state = L_IDLE;
			next_sda   = 1'b0;
			next_scl   = 1'b0;
		end
	end

	always_ff @(posedge bus_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			ls1 <= 2'b00;
			ls2 <= 2'b00;
			ls3 <= 2'b00;
			ps1 <= '{1'b1, 1'b1};
			ps2 <= '{1'b1, 1'b1}; // R18
			pd  <= '{1'b1, 1'b1};
		end else begin
			ls1 <= {en, req_t};
			ls2 <= ls1;
			ls3 <= ls2;
			ps1 <= line_in;
			ps2 <= ps1; // R18
			pd  <= ps2;
		end
	end

	always_ff @(posedge bus_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			state   <= L_IDLE;
			cnt     <= 8'h00;
			bits    <= 8'h00;
			idx     <= 4'h0;
			sda_low <= 1'b0;
			scl_low <= 1'b0;
		end else begin
			state   <= next_state;
			cnt     <= next_cnt;
			bits    <= next_bits;
			idx     <= next_idx;
			sda_low <= next_sda;
			scl_low <= next_scl;
		end
	end

	// Events go to pclk as toggles; the seen flags are slow levels
	always_ff @(posedge bus_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			done_t     <= 1'b0;
			coll_t     <= 1'b0;
			evt_t      <= 1'b0;
			start_seen <= 1'b0;
			stop_seen  <= 1'b0;
		end else begin
			done_t <= done_t ^ (fin | coll | abort);
			coll_t <= coll_t ^ coll;
			evt_t  <= evt_t ^ (fin | stop_det); // R4
			if (!en_s) begin
				start_seen <= 1'b0; // R16
				stop_seen  <= 1'b0;
			end else if (start_det) begin
				start_seen <= 1'b1; // R6
				stop_seen  <= 1'b0;
			end else if (stop_det) begin
				start_seen <= 1'b0;
				stop_seen  <= 1'b1;
			end
		end
	end

	AST_TX_ONE: assert property (@(posedge bus_clk) disable iff (!lrst_n)
		state == L_TX_HIGH && bit_one && !sda_s && en_s |=> state == L_IDLE && !sda_low && !scl_low)
		else $error("lost arbitration on a one not caught"); // R1
	AST_COLL_REL: assert property (@(posedge bus_clk) disable iff (!lrst_n)
		$changed(coll_t) |-> !sda_low && !scl_low && state == L_IDLE) else $error("lines held after collision"); // R3
	AST_ST_LOW: assert property (@(posedge bus_clk) disable iff (!lrst_n)
		state == L_ST_CHK && tmo && !(sda_s && scl_s) |=> $changed(coll_t))
		else $error("start on busy lines not flagged"); // R7
	AST_ST_SCL: assert property (@(posedge bus_clk) disable iff (!lrst_n)
		state == L_ST_WAIT && sda_s && !scl_s |=> state == L_IDLE && !sda_low) else $error("start scl collision missed"); // R8
	AST_CNT: assert property (@(posedge bus_clk) disable iff (!lrst_n)
		state == L_ST_HOLD && cnt != 8'h00 && en_s |=> cnt == $past(cnt) - 8'h01) else $error("counter not stepping"); // R19
	AST_RS_END: assert property (@(posedge bus_clk) disable iff (!lrst_n)
		state == L_RS_HOLD && tmo && en_s |=> scl_low && sda_low && state == L_IDLE) else $error("restart not closed"); // R13
	AST_SP_SCL: assert property (@(posedge bus_clk) disable iff (!lrst_n)
		state == L_SP_CNT && !scl_s && en_s |=> $changed(coll_t)) else $error("stop scl collision missed"); // R15
	AST_STOP_SEEN: assert property (@(posedge bus_clk) disable iff (!lrst_n)
		stop_det && en_s |=> stop_seen && !start_seen && $changed(evt_t)) else $error("bus stop not recorded"); // R4
	AST_SEEN_CLR: assert property (@(posedge bus_clk) disable iff (!lrst_n)
		!en_s |=> !start_seen && !stop_seen) else $error("seen flags kept while disabled"); // R16

endmodule
`default_nettype wire

// file: verif/bcm_bus_peer.sv
/*
 Second master on the shared two-wire bus. It pulls SDA or SCL low
 when the bench tells it to.
 Assumes that the bench resolves the wired-AND levels with pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none

module bcm_bus_peer (
	// Control from the bench
	input  wire logic [1:0] mode,
	// Wire level
	input  wire logic       scl,
	// Pull-down enables
	output logic            sda_oe,
	output logic            scl_oe
);
	// Mode 3 answers every high SCL with a low SDA. No register sits in
	// that path, so the block sees both edges in the same sample.
	assign sda_oe = (mode == 2'h1) || (mode == 2'h3 && scl);
	assign scl_oe = (mode == 2'h2);
endmodule

`default_nettype wire

// file: verif/bcm_top_tb_top.sv
/*
 Self-checking bench for the bus collision port: APB master tasks, a peer
 master on the wire, one task per scenario.
 Assumes the register map of bcm_cfg.svh and pull-ups on both lines.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bcm_cfg.svh"

module bcm_top_tb_top;
	import bcm_pkg::*;
	logic              pclk = 0, bus_clk = 0, presetn = 0;
	logic              psel = 0, penable = 0, pwrite = 0;
	logic [7:0]        paddr = 8'h00;
	logic [31:0]       pwdata = 32'h0, prdata, v;
	logic              pready, pslverr, err;
	bcm_pins_t         line_in, line_o, line_oe;
	logic [1:0]        mode = 2'h0;
	logic              p_sda, p_scl;
	logic [8:0]        bits = 9'h0;
	int                edges = 0, bad_count = 0, num_checks = 0;
	wire               sda_w = ~(line_oe.sda | p_sda);
	wire               scl_w = ~(line_oe.scl | p_scl);
	assign line_in = {sda_w, scl_w};

	bcm_top i_bcm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus_clk(bus_clk), .line_in(line_in), .line_o(line_o), .line_oe(line_oe));
	bcm_bus_peer i_bcm_bus_peer (.mode(mode), .scl(scl_w), .sda_oe(p_sda), .scl_oe(p_scl));

	always #10 pclk = ~pclk;
	initial begin
		#7;
		forever #24 bus_clk = ~bus_clk;
	end
	// Bits seen on the wire, MSB first, one per rising SCL
	always @(posedge scl_w) begin
		bits <= {bits[7:0], sda_w};
		edges <= edges + 1;
	end

	task automatic final_report;
		$display("Checks %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		v = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			bad_count++;
			$display("FAIL %0t no pready", $time);
			final_report();
		end
	endtask

	// Poll a register until the masked bits match, within a bound
	task automatic wait_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		int n;
		n = 0;
		num_checks++;
		do begin
			apb(1'b0, a, 32'h0);
			n++;
		end while ((v & m) !== e && n < 500);
		if ((v & m) !== e) begin
			bad_count++;
			$display("FAIL %0t poll timed out", $time);
			final_report();
		end
	endtask

	task automatic do_start;
		mode <= 2'h0;
		repeat (10) @(posedge bus_clk);
		apb(1'b1, `BCM_OFF_FLAGS, 32'h3);
		apb(1'b1, `BCM_OFF_CTRL2, 32'h1);
		wait_reg(`BCM_OFF_STAT, 32'h2, 32'h0);
	endtask

	task automatic t_reset;
		apb(1'b0, `BCM_OFF_RATE, 32'h0);
		chk(v, {24'h0, `BCM_RATE_RST}, "rate reload reset");
		apb(1'b0, `BCM_OFF_STAT, 32'h0);
		chk(v, 32'h4, "status reset");
		apb(1'b0, `BCM_OFF_FLAGS, 32'h0);
		chk(v, 32'h0, "flags reset");
		apb(1'b0, 8'h18, 32'h0);
		chk(32'(err), 32'h1, "unmapped no error");
		chk(v, 32'h0, "unmapped data");
	endtask

	task automatic t_start;
		do_start();
		chk(32'(line_oe), 32'h3, "start lines");
		chk(32'(line_o), 32'h0, "line data not low");
		apb(1'b0, `BCM_OFF_STAT, 32'h0);
		chk(v & 32'h1f, 32'h08, "start status");
		apb(1'b0, `BCM_OFF_FLAGS, 32'h0);
		chk(v, 32'h1, "start flags");
		apb(1'b1, `BCM_OFF_CTRL2, 32'h2);
		wait_reg(`BCM_OFF_STAT, 32'h2, 32'h0);
		chk(32'(line_oe), 32'h3, "restart lines");
		apb(1'b0, `BCM_OFF_CTRL2, 32'h0);
		chk(v & 32'h17, 32'h0, "restart request left");
	endtask

	// Collision on the last bit of a byte, with a buffer write while busy
	task automatic t_byte_col;
		mode <= 2'h3;
		apb(1'b1, `BCM_OFF_BUF, 32'h01);
		apb(1'b1, `BCM_OFF_BUF, 32'h5a);
		apb(1'b0, `BCM_OFF_CTRL1, 32'h0);
		chk(v & 32'h80, 32'h80, "write collision flag");
		apb(1'b0, `BCM_OFF_BUF, 32'h0);
		chk(v, 32'h01, "buffer overwritten");
		wait_reg(`BCM_OFF_STAT, 32'h2, 32'h0);
		apb(1'b0, `BCM_OFF_FLAGS, 32'h0);
		chk(v & 32'h2, 32'h2, "no collision on byte");
		apb(1'b0, `BCM_OFF_STAT, 32'h0);
		chk(v & 32'h3, 32'h0, "buffer full or busy kept");
		chk(32'(line_oe), 32'h0, "lines held after collision");
	endtask

	task automatic t_bus_stop;
		apb(1'b1, `BCM_OFF_FLAGS, 32'h3);
		mode <= 2'h0;
		wait_reg(`BCM_OFF_FLAGS, 32'h1, 32'h1);
		apb(1'b0, `BCM_OFF_STAT, 32'h0);
		chk(v & 32'h1c, 32'h14, "stop seen, bus free");
	endtask

	task automatic t_resume;
		int e0;
		apb(1'b1, `BCM_OFF_CTRL1, 32'h20);
		e0 = edges;
		apb(1'b1, `BCM_OFF_BUF, 32'ha5);
		wait_reg(`BCM_OFF_STAT, 32'h2, 32'h0);
		chk(32'(edges - e0), 32'd9, "clock count");
		chk(32'(bits[8:1]), 32'ha5, "byte on wire");
		apb(1'b0, `BCM_OFF_CTRL1, 32'h0);
		chk(v & 32'h80, 32'h0, "write refused");
		apb(1'b0, `BCM_OFF_FLAGS, 32'h0);
		chk(v & 32'h2, 32'h0, "false collision");
	endtask

	// Every sequence lost to the peer: start, restart, stop, ack
	task automatic t_seq_col;
		logic [31:0] rq [6];
		logic [1:0]  md [6];
		rq = '{32'h1, 32'h2, 32'h4, 32'h10, 32'h1, 32'h1};
		md = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h1, 2'h2};
		for (int i = 0; i < 6; i++) begin
			do_start();
			mode <= md[i];
			apb(1'b1, `BCM_OFF_CTRL2, rq[i] | 32'h20);
			wait_reg(`BCM_OFF_STAT, 32'h2, 32'h0);
			apb(1'b0, `BCM_OFF_CTRL2, 32'h0);
			chk(v & 32'h17, 32'h0, "request not cleared");
			apb(1'b0, `BCM_OFF_FLAGS, 32'h0);
			chk(v & 32'h2, 32'h2, "collision missed");
			chk(32'(line_oe), 32'h0, "lines not released");
		end
	endtask

	task automatic t_disable;
		do_start();
		apb(1'b0, `BCM_OFF_STAT, 32'h0);
		chk(v & 32'h8, 32'h8, "start not seen");
		apb(1'b1, `BCM_OFF_CTRL1, 32'h0);
		wait_reg(`BCM_OFF_STAT, 32'h18, 32'h0);
		apb(1'b1, `BCM_OFF_CTRL1, 32'h20);
	endtask

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge bus_clk);
		t_reset();
		apb(1'b1, `BCM_OFF_RATE, 32'h2);
		apb(1'b1, `BCM_OFF_CTRL1, 32'h20);
		t_start();
		t_byte_col();
		t_bus_stop();
		t_resume();
		t_seq_col();
		t_disable();
		final_report();
	end
endmodule

`default_nettype wire
